/* src/flash_cmd_cfg.svh */
// Opcodes, field positions, counts and reset values of the serial flash command and protection logic.
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH
`define OP_SET_LATCH 8'h06
`define OP_CLR_LATCH 8'h04
`define OP_READ_IDENT 8'h9F
`define OP_READ_STATUS 8'h05
`define OP_READ_ARRAY 8'h03
`define OP_FAST_READ 8'h0B
`define OP_PAGE_REWRITE 8'h0A
`define OP_PAGE_PROGRAM 8'h02
`define OP_PAGE_ERASE 8'hDB
`define OP_SECTOR_ERASE 8'hD8
`define OP_POWER_DOWN 8'hB9
`define OP_WAKE 8'hAB
`define BYTE_CNT_MAX 4'hF
`define PHASE_LAST 3'h7
`define PHASE_ZERO 3'h0
`define PHASE_ONE 3'h1
`define BYTES_OPCODE 4'h1
`define BYTES_ADDR_ONLY 4'h4
`define BYTES_WITH_DATA 4'h5
`define BYTE_IDX_OP 4'h0
`define BYTE_IDX_A2 4'h1
`define BYTE_IDX_A1 4'h2
`define BYTE_IDX_A0 4'h3
`define PAGE_MSB 16
`define PAGE_LSB 8
`define SECTOR_BIT 16
`define PROT_PAGE_LIMIT 9'h100
`define STATUS_PAD 6'h00
`define SYNC_RESET 4'h8
`define OP_RESET 8'h00
`define ADDR_RESET 24'h000000
`endif

/* src/flash_cmd_pkg.sv */
// Types shared by the serial flash command and protection logic.
package flash_cmd_pkg;
  // Power mode of the device, one-hot.
  typedef enum logic [3:0] {
    MODE_STANDBY = 4'h1,
    MODE_ACTIVE = 4'h2,
    MODE_DEEP = 4'h4,
    MODE_HELD = 4'h8
  } power_mode_t;
  // Kind of internal array cycle handed to the array sequencer.
  typedef enum logic [1:0] {
    CYC_REWRITE = 2'h0,
    CYC_PROGRAM = 2'h1,
    CYC_PAGE_ERASE = 2'h2,
    CYC_SECTOR_ERASE = 2'h3
  } cycle_kind_t;
endpackage : flash_cmd_pkg

/* src/serial_flash_command_protect.sv */
// Command decoder, write latch, busy flag, power modes and write protection of a serial flash.
`timescale 1ns/1ps
`include "flash_cmd_cfg.svh"
// Summary of operation
// - Busy flag stays set during a write, program or erase cycle for polling.
// - Status holds only busy and write latch flags, returned by status read.
// - Chip select low selects the device and, outside deep power-down and reset mode, puts it in active mode.
// - After deselect, stay active until internal cycle ends, then go standby.
// - Power-down opcode enters deep power-down; the wake opcode or reset mode leaves it.
// - In deep power-down every instruction except wake is ignored.
// - Modifying and mode commands execute only if deselect falls on a byte boundary.
// - Rewrite, program and erase are accepted only while the write latch is set.
// - Write latch clears at power-up, reset pin low and acceptance of a modifying command.
// - Set-latch command is one opcode byte and sets the write latch.
// - Write-protect pin low refuses modification of the lowest 256 pages.
// - Array is 512 pages of 256 bytes; page from upper bits, byte low eight.
// - Two 64 KiB sectors: 00000h-0FFFFh and 10000h-1FFFFh.
// - Program clears bits, erase sets bits, rewrite sets either; both erases supported.
// - All bytes travel most significant bit first both ways.
// - Input sampled on each rising serial clock after select; opcode byte first.
// - Decode the status read opcode; identification, array read and fast read are not decoded.
// - Decode rewrite, program with address and data, page and sector erase.
// - Decode clear-latch, power-down and wake as single opcode bytes.
// - Status output follows the opcode; master may deselect after any bit.
// - During an internal cycle, array access attempts are ignored.
// - Master may hold the reset pin low to block modifications.
// - Reset pin low enters reset mode only when no cycle runs.
// - Status bit 0 busy, bit 1 write latch, bits 7 to 2 read zero.
// - Input latched on rising serial clock, output driven from falling edges.
module serial_flash_command_protect (
  // Core clock, reset and freeze.
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Serial link from the bus master.
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  // Protection pins.
  input wire logic DEV_RESET_N,
  input wire logic WP_N,
  // Array sequencer handshake.
  input wire logic CYCLE_DONE,
  output logic CYCLE_START,
  output flash_cmd_pkg::cycle_kind_t CYCLE_KIND,
  output logic [8:0] CYCLE_PAGE,
  output logic CYCLE_SECTOR,
  // Status.
  output logic BUSY,
  output logic WRITE_LATCH,
  output flash_cmd_pkg::power_mode_t POWER_MODE
);
  import flash_cmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // A frame ends on a byte boundary when no partial byte is pending.
  function automatic logic on_boundary(input logic [2:0] phase);
    on_boundary = (phase == `PHASE_ZERO);
  endfunction : on_boundary

  // Lowest pages are read-only while the protect pin is low.
  function automatic logic page_protected(input logic [8:0] page, input logic wp_n);
    page_protected = !wp_n && (page < `PROT_PAGE_LIMIT);
  endfunction : page_protected

  // True for opcodes that start an internal array cycle.
  function automatic logic is_modify(input logic [7:0] op);
    is_modify = (op == `OP_PAGE_REWRITE) || (op == `OP_PAGE_PROGRAM) ||
                (op == `OP_PAGE_ERASE) || (op == `OP_SECTOR_ERASE);
  endfunction : is_modify

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, clocked by the master's serial clock.

  logic [2:0] phase_reg;
  logic [3:0] bytes_reg;
  logic [7:0] shift_reg;
  logic [7:0] op_hold_reg;
  logic [23:0] addr_hold_reg;
  logic [2:0] phase_hold_reg;
  logic [3:0] bytes_hold_reg;
  logic frame_tgl_reg;
  logic [3:0] link_meta_reg;
  logic [3:0] link_sync_reg;
  logic sdo_reg;
  logic sdo_oe_reg;
  logic [7:0] byte_in;
  logic [7:0] status_byte;
  logic status_rd;
  // Core flags, declared ahead of the link logic because the status byte samples them.
  logic busy_reg;
  logic wel_reg;
  logic pd_reg;
  logic held_reg;

  // Bit and byte position inside the frame; deselect clears it at once.
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      phase_reg <= `PHASE_ZERO;
      bytes_reg <= 4'h0;
    end else begin
      phase_reg <= phase_reg + `PHASE_ONE;
      if (phase_reg == `PHASE_LAST && bytes_reg != `BYTE_CNT_MAX) begin
        bytes_reg <= bytes_reg + `BYTES_OPCODE;
      end
    end
  end

  // Serial input shifter, most significant bit first.
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      shift_reg <= `OP_RESET;
    end else begin
      shift_reg <= {shift_reg[6:0], SDI};
    end
  end

  assign byte_in = {shift_reg[6:0], SDI};

  // Frame results that must outlive the deselect edge, so they are not cleared by chip select.
  // The core reads them only after it has seen chip select rise, when the serial clock is quiet.
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      op_hold_reg <= `OP_RESET;
      addr_hold_reg <= `ADDR_RESET;
      phase_hold_reg <= `PHASE_ZERO;
      bytes_hold_reg <= 4'h0;
      frame_tgl_reg <= 1'b0;
    end else if (!CS_N) begin
      phase_hold_reg <= phase_reg + `PHASE_ONE;
      if (phase_reg == `PHASE_LAST && bytes_reg != `BYTE_CNT_MAX) begin
        bytes_hold_reg <= bytes_reg + `BYTES_OPCODE;
      end else begin
        bytes_hold_reg <= bytes_reg;
      end
      // A toggle marks a frame that carried clocks; an empty select pulse is then not mistaken for one.
      if (phase_reg == `PHASE_ZERO && bytes_reg == 4'h0) begin
        frame_tgl_reg <= ~frame_tgl_reg;
      end
      if (phase_reg == `PHASE_LAST) begin
        unique case (bytes_reg)
          `BYTE_IDX_OP: op_hold_reg <= byte_in;
          `BYTE_IDX_A2: addr_hold_reg[23:16] <= byte_in;
          `BYTE_IDX_A1: addr_hold_reg[15:8] <= byte_in;
          `BYTE_IDX_A0: addr_hold_reg[7:0] <= byte_in;
          default: ;
        endcase
      end
    end
  end

  // Status levels cross into the link domain through two flip-flops.
  // The serial clock only runs in frames, so they settle over the opcode byte.
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      link_meta_reg <= 4'h0;
      link_sync_reg <= 4'h0;
    end else begin
      link_meta_reg <= {held_reg, pd_reg, wel_reg, busy_reg};
      link_sync_reg <= link_meta_reg;
    end
  end

  // Status byte layout and status read decode.
  assign status_byte = {`STATUS_PAD, link_sync_reg[1], link_sync_reg[0]};
  assign status_rd = (bytes_reg != 4'h0) && (op_hold_reg == `OP_READ_STATUS) &&
                     !link_sync_reg[2] && !link_sync_reg[3];

  // Output driven from falling edges; deselect releases the line at once.
  always_ff @(negedge SCK or posedge CS_N) begin
    if (CS_N) begin
      sdo_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= status_rd;
      sdo_reg <= status_byte[`PHASE_LAST - phase_reg];
    end
  end

  assign SDO = sdo_reg;
  assign SDO_OE = sdo_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: pin synchronisers and frame end detection.

  logic [3:0] core_meta_reg;
  logic [3:0] core_sync_reg;
  logic cs_prev_reg;
  logic tgl_seen_reg;
  logic cs_s;
  logic tgl_s;
  logic devrst_s;
  logic wp_s;
  logic frame_end;

  // Chip select, frame toggle, reset pin and protect pin pass two flip-flops.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      core_meta_reg <= `SYNC_RESET;
      core_sync_reg <= `SYNC_RESET;
    end else if (CE) begin
      core_meta_reg <= {CS_N, frame_tgl_reg, DEV_RESET_N, WP_N};
      core_sync_reg <= core_meta_reg;
    end
  end

  assign cs_s = core_sync_reg[3];
  assign tgl_s = core_sync_reg[2];
  assign devrst_s = core_sync_reg[1];
  assign wp_s = core_sync_reg[0];

  // Rising chip select of a frame that carried clocks.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cs_prev_reg <= 1'b1;
      tgl_seen_reg <= 1'b0;
    end else if (CE) begin
      cs_prev_reg <= cs_s;
      if (frame_end) begin
        tgl_seen_reg <= tgl_s;
      end
    end
  end

  assign frame_end = cs_s && !cs_prev_reg && (tgl_s != tgl_seen_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: command decision at the end of a frame.

  logic start_reg;
  cycle_kind_t kind_reg;
  cycle_kind_t kind_next;
  logic [8:0] page_reg;
  logic sector_reg;
  power_mode_t mode_reg;
  power_mode_t mode_next;
  logic [8:0] frame_page;
  logic [3:0] need_bytes;
  logic accept;
  logic exec_modify;
  logic exec_set;
  logic exec_clr;
  logic exec_down;
  logic exec_wake;

  // Cycle kind and minimum frame length of modifying opcodes.
  always_comb begin
    kind_next = CYC_REWRITE;
    need_bytes = `BYTES_WITH_DATA;
    unique case (op_hold_reg)
      `OP_PAGE_PROGRAM: kind_next = CYC_PROGRAM;
      `OP_PAGE_ERASE: begin
        kind_next = CYC_PAGE_ERASE;
        need_bytes = `BYTES_ADDR_ONLY;
      end
      `OP_SECTOR_ERASE: begin
        kind_next = CYC_SECTOR_ERASE;
        need_bytes = `BYTES_ADDR_ONLY;
      end
      default: ;
    endcase
  end

  assign frame_page = addr_hold_reg[`PAGE_MSB:`PAGE_LSB];
  // Whole bytes, awake, not in reset mode and no cycle running; other opcodes fall through unused.
  assign accept = frame_end && on_boundary(phase_hold_reg) && (bytes_hold_reg != 4'h0) &&
                  !pd_reg && !held_reg && !busy_reg;
  assign exec_modify = accept && is_modify(op_hold_reg) && wel_reg && (bytes_hold_reg >= need_bytes) &&
                       !page_protected(frame_page, wp_s);
  assign exec_set = accept && (op_hold_reg == `OP_SET_LATCH);
  assign exec_clr = accept && (op_hold_reg == `OP_CLR_LATCH);
  assign exec_down = accept && (op_hold_reg == `OP_POWER_DOWN);
  assign exec_wake = frame_end && pd_reg && !held_reg && on_boundary(phase_hold_reg) &&
                     (bytes_hold_reg != 4'h0) && (op_hold_reg == `OP_WAKE);

  // Cycle start pulse with page, sector and kind for the array sequencer.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      start_reg <= 1'b0;
      kind_reg <= CYC_REWRITE;
      page_reg <= 9'h000;
      sector_reg <= 1'b0;
    end else if (CE) begin
      start_reg <= exec_modify;
      if (exec_modify) begin
        kind_reg <= kind_next;
        page_reg <= frame_page;
        sector_reg <= addr_hold_reg[`SECTOR_BIT];
      end
    end
  end

  // Busy flag: a start wins over a done in the same cycle.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      busy_reg <= 1'b0;
    end else if (CE) begin
      if (exec_modify) begin
        busy_reg <= 1'b1;
      end else if (CYCLE_DONE) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Write latch: cleared by a modifying command as it is taken, by the clear-latch command and by reset mode.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      wel_reg <= 1'b0;
    end else if (CE) begin
      if (exec_modify || exec_clr) begin
        wel_reg <= 1'b0;
      end else if (exec_set) begin
        wel_reg <= 1'b1;
      end else if (held_reg) begin
        wel_reg <= 1'b0;
      end
    end
  end

  // Deep power-down and reset mode flags.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pd_reg <= 1'b0;
      held_reg <= 1'b0;
    end else if (CE) begin
      held_reg <= !devrst_s && (!busy_reg || held_reg);
      if (exec_down) begin
        pd_reg <= 1'b1;
      end else if (exec_wake || held_reg) begin
        pd_reg <= 1'b0;
      end
    end
  end

  // Power mode seen from outside.
  always_comb begin
    if (held_reg) begin
      mode_next = MODE_HELD;
    end else if (pd_reg) begin
      mode_next = MODE_DEEP;
    end else if (!cs_s || busy_reg) begin
      mode_next = MODE_ACTIVE;
    end else begin
      mode_next = MODE_STANDBY;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      mode_reg <= MODE_STANDBY;
    end else if (CE) begin
      mode_reg <= mode_next;
    end
  end

  assign CYCLE_START = start_reg;
  assign CYCLE_KIND = kind_reg;
  assign CYCLE_PAGE = page_reg;
  assign CYCLE_SECTOR = sector_reg;
  assign BUSY = busy_reg;
  assign WRITE_LATCH = wel_reg;
  assign POWER_MODE = mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and cover points.

  start_sets_busy_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    start_reg |-> busy_reg) else $error("cycle start without busy flag");

  start_clears_latch_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    start_reg |-> !wel_reg) else $error("write latch still set after cycle start");

  start_needs_latch_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (start_reg && $past(CE)) |-> $past(wel_reg)) else $error("cycle started without write latch");

  start_on_boundary_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (start_reg && $past(CE)) |-> $past(phase_hold_reg) == `PHASE_ZERO) else $error("cycle from partial byte");

  protect_lower_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (start_reg && $past(CE)) |-> ($past(wp_s) || page_reg >= `PROT_PAGE_LIMIT)) else $error("protected page modified");

  no_overlap_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (start_reg && $past(CE)) |-> !$past(busy_reg)) else $error("cycle started while busy");

  deep_ignores_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (CE && pd_reg && frame_end && op_hold_reg != `OP_WAKE && !held_reg) |=> (pd_reg && !start_reg && wel_reg == $past(wel_reg)))
    else $error("instruction acted in deep power-down");

  deep_wake_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (CE && exec_wake) |=> !pd_reg ##1 (mode_reg != MODE_DEEP)) else $error("wake did not leave deep power-down");

  standby_wait_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (mode_reg == MODE_STANDBY && $past(CE)) |-> (!$past(busy_reg) && $past(cs_s))) else $error("standby while busy");

  held_idle_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (CE && !held_reg && busy_reg) |=> !held_reg) else $error("reset mode entered during a cycle");

  status_off_a: assert property (@(posedge SCK) disable iff (!RST_N)
    (bytes_reg == 4'h0) |-> !SDO_OE) else $error("output driven during opcode byte");

  cover_cycle_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N) start_reg);
  cover_deep_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N) (mode_reg == MODE_DEEP) ##1 exec_wake);
  cover_status_c: cover property (@(negedge SCK) disable iff (!RST_N) SDO_OE && SDO);
  cover_held_c: cover property (@(posedge CORE_CLK) disable iff (!RST_N) mode_reg == MODE_HELD);
endmodule : serial_flash_command_protect

/* tb/spi_master_model.sv */
// Behavioural serial bus master that shifts frames into the flash command logic.
`timescale 1ns/1ps
module spi_master_model #(
  parameter int HALF_NS = 40
) (
  // Serial link towards the device.
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  ////////////////////////////////////////////////////////////////////////////////
  // The link starts deselected with the clock parked low.
  initial begin
    sck = 1'b0;
    // Non-blocking, so the device sees a definite rising select that clears its bit counter.
    cs_n <= 1'b1;
    sdi = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shifts nbits out MSB first and collects what the device returns after the first byte.
  // With cpol low the clock only runs inside a frame; with cpol high it rises before select and stays high after deselect.
  task automatic frame(input logic [47:0] data, input int nbits, input logic cpol,
                       output logic [7:0] rd, output logic oe_ok);
    int i;
    rd = 8'h00;
    oe_ok = 1'b1;
    #7;
    sck = cpol;
    #(HALF_NS);
    cs_n = 1'b0;
    #(HALF_NS);
    for (i = 0; i < nbits; i++) begin
      sck = 1'b0;
      sdi = data[47 - i];
      #(HALF_NS);
      sck = 1'b1;
      if (i >= 8) begin
        rd = {rd[6:0], sdo};
        if (sdo_oe !== 1'b1) oe_ok = 1'b0;
      end
      #(HALF_NS);
    end
    if (!cpol) sck = 1'b0;
    #(HALF_NS);
    cs_n = 1'b1;
    // A released data line must not keep showing the last bit.
    sdi = ~sdi;
  endtask : frame
endmodule : spi_master_model

/* tb/test_serial_flash_command_protect.sv */
// Self-checking bench of the serial flash command and protection logic.
`timescale 1ns/1ps
module test_serial_flash_command_protect;
  import flash_cmd_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b1;
  logic ce = 1'b1;
  logic dev_reset_n = 1'b1;
  logic wp_n = 1'b1;
  logic cycle_done = 1'b0;
  logic sck, cs_n, sdi, sdo, sdo_oe, cycle_start, cycle_sector, busy, write_latch, oe_ok;
  logic [8:0] cycle_page;
  logic [7:0] rd;
  cycle_kind_t cycle_kind;
  power_mode_t power_mode;
  int num_errors = 0;
  int comparisons = 0;
  int num_starts = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Device under test and the bus master at its link.
  serial_flash_command_protect serial_flash_command_protect_i (
    .CORE_CLK(core_clk), .RST_N(rst_n), .CE(ce), .SCK(sck), .CS_N(cs_n), .SDI(sdi),
    .SDO(sdo), .SDO_OE(sdo_oe), .DEV_RESET_N(dev_reset_n), .WP_N(wp_n),
    .CYCLE_DONE(cycle_done), .CYCLE_START(cycle_start), .CYCLE_KIND(cycle_kind),
    .CYCLE_PAGE(cycle_page), .CYCLE_SECTOR(cycle_sector), .BUSY(busy),
    .WRITE_LATCH(write_latch), .POWER_MODE(power_mode)
  );
  spi_master_model spi_master_model_i (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  // The core clock runs at 20 MHz.
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // The start pulse stands one cycle only, so it is counted at the edge that shows it.
  always @(posedge core_clk) begin
    if (cycle_start === 1'b1) num_starts++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic clocks(input int n);
    repeat (n) @(posedge core_clk);
  endtask : clocks

  function automatic logic [47:0] op(input logic [7:0] b);
    return {b, 40'h0};
  endfunction : op

  // Waits long enough after deselect for the command to land and the gap rule to hold.
  task automatic send(input logic [47:0] data, input int nbits, input logic cpol = 1'b0);
    spi_master_model_i.frame(data, nbits, cpol, rd, oe_ok);
    clocks(10);
  endtask : send

  task automatic status(input logic [7:0] exp, input logic cpol);
    send({8'h05, 40'h0}, 16, cpol);
    chk(rd, exp, "status byte");
    chk(oe_ok, 1'b1, "output enable while shifting");
    chk(sdo_oe, 1'b0, "output released after deselect");
  endtask : status

  task automatic done_pulse();
    @(posedge core_clk) cycle_done <= 1'b1;
    @(posedge core_clk) cycle_done <= 1'b0;
    clocks(4);
    chk(busy, 1'b0, "busy cleared by done");
  endtask : done_pulse

  task automatic report_and_stop();
    $display("Mismatches: %0d, comparisons: %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    chk(busy, 1'b0, "busy after reset");
    chk(write_latch, 1'b0, "latch after reset");
    chk(power_mode, MODE_STANDBY, "standby after reset");
    chk(sdo_oe, 1'b0, "output idle after reset");
  endtask : t_reset

  task automatic t_latch();
    send(op(8'h06), 7);
    chk(write_latch, 1'b0, "partial set-latch frame");
    send(op(8'h06), 8);
    chk(write_latch, 1'b1, "set latch");
    status(8'h02, 1'b0);
    status(8'h02, 1'b1);
    // Deselect after four output bits: the line is released and the bits seen are the top of 02h.
    send({8'h05, 40'h0}, 12);
    chk(rd, 8'h00, "status bits before early deselect");
    chk(sdo_oe, 1'b0, "output released after early deselect");
    send(op(8'h77), 8);
    chk(write_latch, 1'b1, "unknown opcode");
    send(op(8'h04), 8);
    chk(write_latch, 1'b0, "clear latch");
    status(8'h00, 1'b0);
  endtask : t_latch

  task automatic t_modify();
    logic [7:0] ops [4];
    logic [23:0] adr [4];
    int n;
    ops = '{8'h0A, 8'h02, 8'hDB, 8'hD8};
    adr = '{24'h000100, 24'h01FF00, 24'h00FF00, 24'h010000};
    n = num_starts;
    send({8'hDB, 24'h012300, 16'h0}, 32);
    chk(16'(num_starts), 16'(n), "erase without latch");
    send(op(8'h06), 8);
    @(posedge core_clk) wp_n <= 1'b0;
    send({8'hDB, 24'h00FF00, 16'h0}, 32);
    chk(16'(num_starts), 16'(n), "protected page");
    send({8'hDB, 24'h01FF00, 16'h0}, 35);
    chk(16'(num_starts), 16'(n), "erase ending mid-byte");
    send({8'hDB, 24'h010000, 16'h0}, 32);
    chk(16'(num_starts), 16'(n + 1), "first page above protection");
    chk(cycle_page, 9'h100, "page of first sector-one address");
    chk(cycle_sector, 1'b1, "sector of 10000h");
    done_pulse();
    @(posedge core_clk) wp_n <= 1'b1;
    // Every modifying command in turn, each needing its own set-latch frame.
    for (int k = 0; k < 4; k++) begin
      send(op(8'h06), 8);
      send({ops[k], adr[k], 8'hA5, 8'h0}, k < 2 ? 40 : 32);
      chk(16'(num_starts), 16'(n + 2 + k), "cycle accepted");
      chk(cycle_kind, 16'(k), "cycle kind");
      chk(cycle_page, adr[k][16:8], "cycle page");
      chk(cycle_sector, adr[k][16], "cycle sector");
      chk(busy, 1'b1, "busy during cycle");
      chk(write_latch, 1'b0, "latch cleared on start");
      chk(power_mode, MODE_ACTIVE, "active while cycle runs");
      status(8'h01, 1'b0);
      send({8'hDB, 24'h000000, 16'h0}, 32);
      chk(16'(num_starts), 16'(n + 2 + k), "access while busy");
      done_pulse();
      chk(power_mode, MODE_STANDBY, "standby after cycle");
    end
  endtask : t_modify

  task automatic t_power();
    send(op(8'hB9), 8);
    chk(power_mode, MODE_DEEP, "deep power-down");
    send(op(8'h06), 8);
    chk(write_latch, 1'b0, "set latch while deep");
    send(op(8'hAB), 7);
    chk(power_mode, MODE_DEEP, "wake ending mid-byte");
    send(op(8'hAB), 8);
    chk(power_mode, MODE_STANDBY, "woken");
  endtask : t_power

  // A low clock enable freezes the core, so a done pulse then goes unseen and busy stays.
  task automatic t_freeze();
    send(op(8'h06), 8);
    send({8'hD8, 24'h010000, 16'h0}, 32);
    chk(busy, 1'b1, "busy before freeze");
    @(posedge core_clk) ce <= 1'b0;
    @(posedge core_clk) cycle_done <= 1'b1;
    @(posedge core_clk) cycle_done <= 1'b0;
    clocks(2);
    chk(busy, 1'b1, "busy held while clock enable is low");
    @(posedge core_clk) ce <= 1'b1;
    done_pulse();
  endtask : t_freeze

  task automatic t_pin();
    send(op(8'h06), 8);
    @(posedge core_clk) dev_reset_n <= 1'b0;
    clocks(6);
    chk(power_mode, MODE_HELD, "reset mode");
    chk(write_latch, 1'b0, "latch cleared by reset pin");
    send(op(8'h06), 8);
    chk(write_latch, 1'b0, "command in reset mode");
    @(posedge core_clk) dev_reset_n <= 1'b1;
    clocks(6);
    chk(power_mode, MODE_STANDBY, "reset pin released");
    send(op(8'h06), 8);
    send({8'hD8, 24'h000000, 16'h0}, 32);
    @(posedge core_clk) dev_reset_n <= 1'b0;
    clocks(6);
    chk(power_mode, MODE_ACTIVE, "reset pin waits for cycle");
    done_pulse();
    clocks(2);
    chk(power_mode, MODE_HELD, "reset mode after cycle");
    @(posedge core_clk) dev_reset_n <= 1'b1;
    clocks(6);
  endtask : t_pin

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: twelve cycles of reset, then a settling gap for the synchronisers.
  initial begin
    // Non-blocking at time zero, so the falling reset is an event that the link registers see.
    rst_n <= 1'b0;
    clocks(12);
    rst_n <= 1'b1;
    clocks(6);
    t_reset();
    t_latch();
    t_modify();
    t_power();
    t_freeze();
    t_pin();
    report_and_stop();
  end

  // The whole run needs well under a quarter of this span.
  initial begin
    #1000000;
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : test_serial_flash_command_protect
